//--- crcr_defines.svh
/*
 * Register offsets, field positions, reset values and algorithm constants
 * of the reflected CRC-32 engine.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef CRCR_DEFINES_SVH
`define CRCR_DEFINES_SVH

// ****************************************************************
// Register map (special function register addresses)
// ****************************************************************
`define CRCR_ADDR_INPUT     8'hdd
`define CRCR_ADDR_RESULT    8'hde
`define CRCR_ADDR_CONTROL   8'hce

// ****************************************************************
// Control register fields
// ****************************************************************
`define CRCR_CTL_PTR_LSB    0
`define CRCR_CTL_PTR_MSB    1
`define CRCR_CTL_INIT_VAL   2
`define CRCR_CTL_INIT_GO    3

// ****************************************************************
// Reset values
// ****************************************************************
`define CRCR_RST_INPUT      8'h00
`define CRCR_RST_CONTROL    8'h00
`define CRCR_RST_ACC        32'h00000000

// ****************************************************************
// Algorithm constants
// ****************************************************************
`define CRCR_POLY_NORMAL    32'h04c11db7
`define CRCR_POLY_REFLECT   32'hedb88320
`define CRCR_INIT_ONES      32'hffffffff
`define CRCR_INIT_ZEROS     32'h00000000
`define CRCR_BITS_PER_BYTE  8

`endif

//--- crcr_pkg.sv
/*
 * Types used by the reflected CRC-32 engine top; its byte FIFO uses none of them.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package crcr_pkg;

    // ****************************************************************
    // Register access carrier
    // ****************************************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } crcr_sfr_req_type;

    typedef enum logic [0:0] {
        CRCR_IDLE = 1'b0,
        CRCR_FOLD = 1'b1
    } crcr_state_type;

endpackage : crcr_pkg

//--- crcr_engine.sv
/*
 * Reflected CRC-32 engine with special function register access, and
 * the small FIFO that queues written input bytes ahead of the folder.
 * Assumes a synchronous register port on CORE_CLK from the CPU core;
 * reads return data on the cycle after the strobe.
 */
//
// Behaviour
// - Compute a 32-bit CRC over written bytes with polynomial 04C11DB7.
// - Work in reflected form: input bytes and result bit-reversed.
// - XOR each byte into the low eight accumulator bits first.
// - Accumulator starts from selected initial value, all zeros or all ones.
// - Each bit step shifts right; XOR 0xEDB88320 when shifted-out bit one.
// - Exactly eight shift-and-XOR steps per input byte.
// - Each write to the input register folds that byte; register resets zero. Here an initialise write drops the byte then at the FIFO head, unfolded.
// - Result register accesses the accumulator byte chosen by the pointer.
`timescale 1ns/1ps
`include "crcr_defines.svh"

// ****************************************************************
// Byte FIFO
// ****************************************************************
module crcr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  empty
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign empty     = ~out_valid;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_reg[rptr_reg];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : crcr_fifo

// ****************************************************************
// Engine top
// ****************************************************************
module crcr_engine #(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic       CORE_CLK,
    input  wire logic       RESET_N,
    input  wire logic       SFR_WR,
    input  wire logic       SFR_RD,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic [7:0] SFR_WDATA,
    output logic      [7:0] SFR_RDATA,
    output logic            SFR_HIT,
    output logic            SFR_READY,
    output logic            CRC_BUSY
);
    crcr_pkg::crcr_sfr_req_type req;
    crcr_pkg::crcr_state_type   state_reg;
    logic [31:0] acc_reg;
    logic [31:0] acc_next;
    logic [7:0]  input_reg;
    logic [7:0]  control_reg;
    logic [7:0]  rdata_reg;
    logic        in_ready;
    logic        fifo_valid;
    logic        fifo_empty;
    logic [7:0]  fifo_data;
    logic        wr_input;
    logic        wr_result;
    logic        wr_control;
    logic        rd_any;
    logic        idle;
    logic [1:0]  ptr;

    // Eight reflected shift steps on one byte, unrolled combinationally
    function automatic logic [31:0] fold_byte(input logic [31:0] acc,
                                              input logic [7:0]  data);
        logic [31:0] c;
        c = acc ^ {24'h000000, data};
        for (int i = 0; i < `CRCR_BITS_PER_BYTE; i++) begin
            c = c[0] ? ((c >> 1) ^ `CRCR_POLY_REFLECT) : (c >> 1);
        end
        return c;
    endfunction : fold_byte

    assign req        = '{wr: SFR_WR, rd: SFR_RD,
                          addr: SFR_ADDR, wdata: SFR_WDATA};
    assign idle       = fifo_empty & (state_reg == crcr_pkg::CRCR_IDLE);
    assign ptr        = control_reg[`CRCR_CTL_PTR_MSB:`CRCR_CTL_PTR_LSB];
    assign SFR_HIT    = (req.addr == `CRCR_ADDR_INPUT) |
                        (req.addr == `CRCR_ADDR_RESULT) |
                        (req.addr == `CRCR_ADDR_CONTROL);
    // Result register accesses wait until queued bytes are folded; control writes never wait
    assign SFR_READY  = (req.addr == `CRCR_ADDR_INPUT)  ? in_ready :
                        (req.addr == `CRCR_ADDR_RESULT) ? idle : 1'b1;
    assign wr_input   = req.wr & (req.addr == `CRCR_ADDR_INPUT) & in_ready;
    assign wr_result  = req.wr & (req.addr == `CRCR_ADDR_RESULT) & idle;
    assign wr_control = req.wr & (req.addr == `CRCR_ADDR_CONTROL);
    assign rd_any     = req.rd & SFR_READY;
    assign CRC_BUSY   = ~idle;
    assign SFR_RDATA  = rdata_reg;

    crcr_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CORE_CLK),
        .rst_n     (RESET_N),
        .in_valid  (wr_input),
        .in_ready  (in_ready),
        .in_data   (req.wdata),
        .out_valid (fifo_valid),
        .out_ready (1'b1),
        .out_data  (fifo_data),
        .empty     (fifo_empty)
    );

    // ****************************************************************
    // Input and control registers
    // ****************************************************************
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            input_reg <= `CRCR_RST_INPUT;
        end else if (wr_input) begin
            input_reg <= req.wdata;
        end
    end

    // Initialise strobe is self-clearing and never stored
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            control_reg <= `CRCR_RST_CONTROL;
        end else if (wr_control) begin
            control_reg <= req.wdata & ~(8'h01 << `CRCR_CTL_INIT_GO);
        end
    end

    // ****************************************************************
    // Accumulator
    // ****************************************************************
    always_comb begin
        acc_next = acc_reg;
        if (wr_control && req.wdata[`CRCR_CTL_INIT_GO]) begin
            acc_next = req.wdata[`CRCR_CTL_INIT_VAL] ?
                       `CRCR_INIT_ONES : `CRCR_INIT_ZEROS;
        end else if (fifo_valid) begin
            acc_next = fold_byte(acc_reg, fifo_data);
        end else if (wr_result) begin
            acc_next[8*ptr +: 8] = req.wdata;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            acc_reg <= `CRCR_RST_ACC;
        end else begin
            acc_reg <= acc_next;
        end
    end

    // Folding takes one cycle per queued byte
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_reg <= crcr_pkg::CRCR_IDLE;
        end else begin
            state_reg <= fifo_valid ? crcr_pkg::CRCR_FOLD
                                    : crcr_pkg::CRCR_IDLE;
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_reg <= 8'h00;
        end else if (rd_any) begin
            unique case (req.addr)
                `CRCR_ADDR_INPUT:   rdata_reg <= input_reg;
                `CRCR_ADDR_RESULT:  rdata_reg <= acc_reg[8*ptr +: 8];
                `CRCR_ADDR_CONTROL: rdata_reg <= control_reg;
                default:            rdata_reg <= 8'h00;
            endcase
        end
    end
endmodule : crcr_engine

//--- crcr_engine_checker.sv
/*
 * Port-level assertions of the CRC engine top.
 * Assumes binding onto crcr_engine; one clock domain.
 */
`timescale 1ns/1ps
module crcr_engine_checker #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic       CORE_CLK,
    input wire logic       RESET_N,
    input wire logic       SFR_WR,
    input wire logic       SFR_RD,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_RDATA,
    input wire logic       SFR_HIT,
    input wire logic       SFR_READY,
    input wire logic       CRC_BUSY
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    a_hit_decode: assert property (SFR_HIT == (SFR_ADDR == 8'hdd ||
        SFR_ADDR == 8'hde || SFR_ADDR == 8'hce)) else $error("hit decode");
    a_write_queues: assert property (SFR_WR && SFR_READY &&
        SFR_ADDR == 8'hdd |=> CRC_BUSY) else $error("write not queued");
    a_fold_drains: assert property ((CRC_BUSY && !SFR_WR)[*8]
        |-> !CRC_BUSY) else $error("folding never ends");
    a_result_stall: assert property ((SFR_RD || SFR_WR) && CRC_BUSY &&
        SFR_ADDR == 8'hde |-> !SFR_READY) else $error("result not stalled");
    a_idle_ready: assert property (!CRC_BUSY |-> SFR_READY)
        else $error("idle access refused");
    a_unmapped_zero: assert property (SFR_RD && SFR_READY && !SFR_HIT
        |=> SFR_RDATA == 8'h00) else $error("unmapped read not zero");
    a_rdata_holds: assert property (!(SFR_RD && SFR_READY)
        |=> $stable(SFR_RDATA)) else $error("read data moved");
    a_control_ready: assert property ((SFR_RD || SFR_WR) &&
        SFR_ADDR == 8'hce |-> SFR_READY) else $error("control refused");
endmodule : crcr_engine_checker
bind crcr_engine crcr_engine_checker #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (.*);

//--- crcr_engine_bench.sv
/*
 * Self-checking bench of the CRC engine against an integer model.
 * Assumes crcr_engine with its default FIFO depth.
 */
`timescale 1ns/1ps
module crcr_engine_bench;
    logic        clk = 0, rst_n = 0, wr = 0, rd = 0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, d;
    logic        hit, ready, busy;
    int unsigned acc = 0, lfsr = 32'h3941, cycles = 0;
    int          n_errors = 0, check_count = 0;
    crcr_engine i_crcr_engine (.CORE_CLK(clk), .RESET_N(rst_n),
        .SFR_WR(wr), .SFR_RD(rd), .SFR_ADDR(addr), .SFR_WDATA(wdata),
        .SFR_RDATA(rdata), .SFR_HIT(hit), .SFR_READY(ready),
        .CRC_BUSY(busy));
    initial forever #12.5 clk = ~clk;
    // ****************************************************************
    // Model and bus tasks
    // ****************************************************************
    function automatic int unsigned fold(int unsigned a, logic [7:0] b);
        a = a ^ b;
        for (int i = 0; i < 8; i++) begin
            a = a[0] ? (a >> 1) ^ 32'hedb88320 : a >> 1;
        end
        return a;
    endfunction : fold
    function automatic int unsigned lfsr_next(int unsigned s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        check_count++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            n_errors++;
        end
    endtask : chk
    // Handshake: ready is sampled mid-cycle, request held until taken
    task automatic acc_bus(logic w, logic [7:0] a, logic [7:0] v);
        bit ok;
        @(posedge clk);
        wr <= w; rd <= !w; addr <= a; wdata <= v;
        do begin
            @(negedge clk); ok = ready; @(posedge clk);
        end while (!ok);
        wr <= 0; rd <= 0;
        @(posedge clk); @(negedge clk);
        d = rdata;
    endtask : acc_bus
    task automatic put(logic [7:0] v);
        acc_bus(1, 8'hdd, v);
        acc = fold(acc, v);
    endtask : put
    task automatic init(bit ones);
        acc_bus(1, 8'hce, {4'h0, 1'b1, ones, 2'h0});
        acc = ones ? 32'hffffffff : 32'h00000000;
    endtask : init
    task automatic chk_acc();
        for (int i = 0; i < 4; i++) begin
            acc_bus(1, 8'hce, 8'(i));
            acc_bus(0, 8'hde, 8'h00);
            chk("result byte", d, acc[8*i+:8]);
        end
    endtask : chk_acc
    task automatic conclude();
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1;
        acc_bus(0, 8'hdd, 8'h00); chk("input reset", d, 8'h00);
        acc_bus(0, 8'he0, 8'h00); chk("unmapped", d, 8'h00);
        chk_acc();
        init(1); put(8'h63); chk_acc();
        chk("table 63", acc, 32'hf9462090);
        acc_bus(0, 8'hdd, 8'h00); chk("input readback", d, 8'h63);
        init(1); put(8'haa); put(8'hbb); put(8'hcc); chk_acc();
        chk("table 3", acc, 32'h41b207b3);
        init(1); put(8'h00); put(8'h00); put(8'haa); put(8'hbb);
        put(8'hcc); chk_acc();
        chk("table 5", acc, 32'h78d129bc);
        init(0);
        for (int i = 0; i < 24; i++) begin
            lfsr = lfsr_next(lfsr);
            put(lfsr[7:0]);
        end
        chk_acc();
        acc_bus(1, 8'hce, 8'h02); acc_bus(1, 8'hde, 8'h5a);
        acc[23:16] = 8'h5a;
        put(8'h3c); chk_acc();
        conclude();
    end
endmodule : crcr_engine_bench
